// ---- hw/qwr_bank.sv ----
// Quad wiper register bank with two-wire serial slave.
`timescale 1ns/1ps
module qwr_bank
	import qwr_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe_n,
	input  wire logic                select_pin_0,
	input  wire logic                select_pin_1,
	input  wire logic                select_pin_2,
	output logic      [7:0]          wiper_ch0,
	output logic      [7:0]          wiper_ch1,
	output logic      [7:0]          wiper_ch2,
	output logic      [7:0]          wiper_ch3,
	output logic      [QWR_TAPS-1:0] tap_sel_ch0,
	output logic      [QWR_TAPS-1:0] tap_sel_ch1,
	output logic      [QWR_TAPS-1:0] tap_sel_ch2,
	output logic      [QWR_TAPS-1:0] tap_sel_ch3
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] scl_sync_ff;
	logic [2:0] sda_sync_ff;
	logic [2:0] sel_sync_ff [3];
	logic       scl_ff;
	logic       sda_ff;
	logic       scl_q_ff;
	logic       sda_q_ff;
	logic [2:0] sel_ff;
	logic [2:0] nxt_sel;

	// Three stages; a level counts once stages two and three agree.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
			sel_sync_ff <= '{3'h0, 3'h0, 3'h0};
			scl_ff      <= 1'b1;
			sda_ff      <= 1'b1;
			scl_q_ff    <= 1'b1;
			sda_q_ff    <= 1'b1;
			sel_ff      <= 3'h0;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
			sel_sync_ff[0] <= {sel_sync_ff[0][1:0], select_pin_0};
			sel_sync_ff[1] <= {sel_sync_ff[1][1:0], select_pin_1};
			sel_sync_ff[2] <= {sel_sync_ff[2][1:0], select_pin_2};
			if (scl_sync_ff[2] == scl_sync_ff[1]) begin
				scl_ff <= scl_sync_ff[2];
			end
			if (sda_sync_ff[2] == sda_sync_ff[1]) begin
				sda_ff <= sda_sync_ff[2];
			end
			scl_q_ff <= scl_ff;
			sda_q_ff <= sda_ff;
			sel_ff   <= nxt_sel;
		end
	end

	// Select pins follow the same agreement filter per bit.
	always_comb begin
		nxt_sel = sel_ff;
		for (int i = 0; i < 3; i++) begin
			if (sel_sync_ff[i][2] == sel_sync_ff[i][1]) begin
				nxt_sel[i] = sel_sync_ff[i][2];
			end
		end
	end

	// Bus events taken from the filtered levels.
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise  = scl_ff & ~scl_q_ff;
	assign scl_fall  = ~scl_ff & scl_q_ff;
	assign start_det = scl_ff & scl_q_ff & sda_q_ff & ~sda_ff;
	assign stop_det  = scl_ff & scl_q_ff & ~sda_q_ff & sda_ff;

	// ----------------------------------------
	// Serial engine
	// ----------------------------------------
	qwr_state_type state_ff, nxt_state;
	logic [3:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic [1:0] ptr_ff, nxt_ptr;
	logic       ack_ok_ff, nxt_ack_ok;
	logic       drive_ff, nxt_drive;
	logic       out_bit_ff, nxt_out_bit;
	logic [7:0] wiper_ff [QWR_NUM_CH];
	logic [7:0] nxt_wiper [QWR_NUM_CH];
	logic [7:0] rx_byte;

	assign rx_byte = {shift_ff[6:0], sda_ff};

	// Checks an identification byte against type code and select pins.
	function automatic logic id_match(input logic [7:0] b,
		input logic [2:0] sel);
		id_match = (b[QWR_ID_TYPE_MSB:QWR_ID_TYPE_LSB] == QWR_DEV_TYPE) &&
			(b[QWR_ID_SEL_MSB:QWR_ID_SEL_LSB] == sel);
	endfunction

	// Byte level protocol with ack on the ninth clock.
	always_comb begin
		nxt_state   = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift   = shift_ff;
		nxt_ptr     = ptr_ff;
		nxt_ack_ok  = ack_ok_ff;
		nxt_drive   = drive_ff;
		nxt_out_bit = out_bit_ff;
		nxt_wiper   = wiper_ff;
		if (start_det) begin
			// The fall that ends START must not count as a data bit.
			nxt_state   = QWR_ID_BYTE;
			nxt_bit_cnt = QWR_BIT_START;
			nxt_drive   = 1'b0;
		end else if (stop_det) begin
			nxt_state = QWR_IDLE;
			nxt_drive = 1'b0;
		end else if (scl_rise) begin
			// While sending, the shifter is only moved on the falling clock.
			if (state_ff == QWR_READ_BYTE) begin
				if (bit_cnt_ff == QWR_BIT_ACK) begin
					nxt_ack_ok = ~sda_ff;
				end
			end else if (bit_cnt_ff <= QWR_BIT_LAST) begin
				nxt_shift = rx_byte;
			end
		end else if (scl_fall) begin
			nxt_bit_cnt = bit_cnt_ff + 4'h1;
			nxt_drive   = 1'b0;
			case (state_ff)
			QWR_IDLE, QWR_IGNORE: begin
				nxt_bit_cnt = 4'h0;
			end
			QWR_ID_BYTE: begin
				if (bit_cnt_ff == QWR_BIT_LAST) begin
					if (id_match(shift_ff, sel_ff)) begin
						nxt_drive   = 1'b1;
						nxt_out_bit = 1'b0;
						nxt_ack_ok  = 1'b1;
					end else begin
						nxt_state = QWR_IGNORE;
					end
				end else if (bit_cnt_ff == QWR_BIT_ACK) begin
					nxt_bit_cnt = 4'h0;
					if (shift_ff[QWR_ID_RW_BIT]) begin
						nxt_state   = QWR_READ_BYTE;
						nxt_drive   = 1'b1;
						nxt_out_bit = wiper_ff[ptr_ff][7];
						nxt_shift   = wiper_ff[ptr_ff];
					end else begin
						nxt_state = QWR_ADDR_BYTE;
					end
				end
			end
			QWR_ADDR_BYTE, QWR_DATA_BYTE: begin
				if (bit_cnt_ff == QWR_BIT_LAST) begin
					nxt_drive   = 1'b1;
					nxt_out_bit = 1'b0;
					if (state_ff == QWR_ADDR_BYTE) begin
						nxt_ptr = shift_ff[1:0];
					end else begin
						nxt_wiper[ptr_ff] = shift_ff;
					end
				end else if (bit_cnt_ff == QWR_BIT_ACK) begin
					nxt_bit_cnt = 4'h0;
					nxt_state   = (state_ff == QWR_ADDR_BYTE) ?
						QWR_DATA_BYTE : QWR_IGNORE;
				end
			end
			QWR_READ_BYTE: begin
				if (bit_cnt_ff < QWR_BIT_LAST) begin
					nxt_drive   = 1'b1;
					nxt_out_bit = shift_ff[6];
					nxt_shift   = {shift_ff[6:0], 1'b0};
				end else if (bit_cnt_ff == QWR_BIT_LAST) begin
					nxt_ptr = ptr_ff + 2'h1;
				end else begin
					nxt_bit_cnt = 4'h0;
					if (ack_ok_ff) begin
						nxt_drive   = 1'b1;
						nxt_out_bit = wiper_ff[ptr_ff][7];
						nxt_shift   = wiper_ff[ptr_ff];
					end else begin
						nxt_state = QWR_IGNORE;
					end
				end
			end
			default: nxt_state = QWR_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff   <= QWR_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff   <= 8'h00;
			ptr_ff     <= 2'h0;
			ack_ok_ff  <= 1'b0;
			drive_ff   <= 1'b0;
			out_bit_ff <= 1'b1;
			wiper_ff   <= '{QWR_WIPER_RST, QWR_WIPER_RST,
				QWR_WIPER_RST, QWR_WIPER_RST};
		end else begin
			state_ff   <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff   <= nxt_shift;
			ptr_ff     <= nxt_ptr;
			ack_ok_ff  <= nxt_ack_ok;
			drive_ff   <= nxt_drive;
			out_bit_ff <= nxt_out_bit;
			wiper_ff   <= nxt_wiper;
		end
	end

	// ----------------------------------------
	// Pin and channel outputs
	// ----------------------------------------
	// Open drain: enable low only while pulling the line low.
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~(drive_ff & ~out_bit_ff);
	assign wiper_ch0 = wiper_ff[0];
	assign wiper_ch1 = wiper_ff[1];
	assign wiper_ch2 = wiper_ff[2];
	assign wiper_ch3 = wiper_ff[3];

	qwr_tap_decode u_dec0 (.wiper(wiper_ff[0]), .tap_sel(tap_sel_ch0));
	qwr_tap_decode u_dec1 (.wiper(wiper_ff[1]), .tap_sel(tap_sel_ch1));
	qwr_tap_decode u_dec2 (.wiper(wiper_ff[2]), .tap_sel(tap_sel_ch2));
	qwr_tap_decode u_dec3 (.wiper(wiper_ff[3]), .tap_sel(tap_sel_ch3));

endmodule

// ---- hw/qwr_pkg.sv ----
// Package of constants for the quad wiper register bank.
package qwr_pkg;

	// ----------------------------------------
	// Register map and reset values
	// ----------------------------------------
	localparam int        QWR_NUM_CH        = 4;
	localparam int        QWR_TAPS          = 256;
	localparam logic [7:0] QWR_OFS_CH0      = 8'h00;
	localparam logic [7:0] QWR_OFS_CH1      = 8'h01;
	localparam logic [7:0] QWR_OFS_CH2      = 8'h02;
	localparam logic [7:0] QWR_OFS_CH3      = 8'h03;
	localparam logic [7:0] QWR_WIPER_RST    = 8'h80;
	localparam logic [7:0] QWR_TAP_LOW      = 8'h00;
	localparam logic [7:0] QWR_TAP_HIGH     = 8'hFF;

	// ----------------------------------------
	// Identification byte fields
	// ----------------------------------------
	// Device type code; value is arbitrary.
	localparam logic [3:0] QWR_DEV_TYPE     = 4'hA;
	localparam int        QWR_ID_TYPE_MSB   = 7;
	localparam int        QWR_ID_TYPE_LSB   = 4;
	localparam int        QWR_ID_SEL_MSB    = 3;
	localparam int        QWR_ID_SEL_LSB    = 1;
	localparam int        QWR_ID_RW_BIT     = 0;
	localparam logic [3:0] QWR_BIT_LAST     = 4'h7;
	localparam logic [3:0] QWR_BIT_ACK      = 4'h8;
	// Count loaded at START; the clock fall that closes START wraps it to 0.
	localparam logic [3:0] QWR_BIT_START    = 4'hF;

	// ----------------------------------------
	// Serial engine states
	// ----------------------------------------
	typedef enum logic [2:0] {
		QWR_IDLE,
		QWR_ID_BYTE,
		QWR_ADDR_BYTE,
		QWR_DATA_BYTE,
		QWR_READ_BYTE,
		QWR_IGNORE
	} qwr_state_type;

endpackage

// ---- hw/qwr_tap_decode.sv ----
// One-hot tap select decoder for one channel.
`timescale 1ns/1ps
module qwr_tap_decode
	import qwr_pkg::*;
(
	input  wire logic [7:0]          wiper,
	output logic      [QWR_TAPS-1:0] tap_sel
);

	// ----------------------------------------
	// Decoder
	// ----------------------------------------
	// one select per code
	// Code 0 drives the lowest select, code 255 the highest.
	always_comb begin
		tap_sel = '0;
		tap_sel[wiper] = 1'b1;
	end

endmodule

// ---- sim/qwr_bank_sva.sv ----
// Port checker for the quad wiper register bank.
`timescale 1ns/1ps
module qwr_bank_sva
	import qwr_pkg::*;
(
	input wire logic                ref_clk,
	input wire logic                rst,
	input wire logic                scl_in,
	input wire logic                sda_out,
	input wire logic                sda_oe_n,
	input wire logic [7:0]          wiper_ch0,
	input wire logic [7:0]          wiper_ch1,
	input wire logic [7:0]          wiper_ch2,
	input wire logic [7:0]          wiper_ch3,
	input wire logic [QWR_TAPS-1:0] tap_sel_ch0,
	input wire logic [QWR_TAPS-1:0] tap_sel_ch1,
	input wire logic [QWR_TAPS-1:0] tap_sel_ch2,
	input wire logic [QWR_TAPS-1:0] tap_sel_ch3
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Each tap select is the one-hot image of its own wiper only.
	a_tap_ch0: assert property (tap_sel_ch0 == 256'h1 << wiper_ch0)
		else $error("Tap select of channel 0 wrong.");
	a_tap_ch1: assert property (tap_sel_ch1 == 256'h1 << wiper_ch1)
		else $error("Tap select of channel 1 wrong.");
	a_tap_ch2: assert property (tap_sel_ch2 == 256'h1 << wiper_ch2)
		else $error("Tap select of channel 2 wrong.");
	a_tap_ch3: assert property (tap_sel_ch3 == 256'h1 << wiper_ch3)
		else $error("Tap select of channel 3 wrong.");
	// Wipers leave reset at mid-scale.
	a_mid_reset: assert property ($fell(rst) |-> wiper_ch0 == 8'h80 &&
		wiper_ch1 == 8'h80 && wiper_ch2 == 8'h80 && wiper_ch3 == 8'h80)
		else $error("Wiper not mid-scale after reset.");
	// The data pin is only ever pulled low.
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("Data output not low.");
	a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("Data drive changed while clock high.");
	a_wiper_scl_low: assert property ($changed({wiper_ch0, wiper_ch1,
		wiper_ch2, wiper_ch3}) |-> !scl_in)
		else $error("Wiper changed while clock high.");
	a_one_channel: assert property ($onehot0({$changed(wiper_ch0),
		$changed(wiper_ch1), $changed(wiper_ch2), $changed(wiper_ch3)}))
		else $error("Several wipers changed at once.");
	c_ack: cover property ($fell(sda_oe_n));
	c_wr0: cover property ($changed(wiper_ch0));
	c_wr3: cover property ($changed(wiper_ch3));
endmodule

bind qwr_bank qwr_bank_sva u_sva (.ref_clk(ref_clk), .rst(rst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.wiper_ch0(wiper_ch0), .wiper_ch1(wiper_ch1), .wiper_ch2(wiper_ch2),
	.wiper_ch3(wiper_ch3), .tap_sel_ch0(tap_sel_ch0),
	.tap_sel_ch1(tap_sel_ch1), .tap_sel_ch2(tap_sel_ch2),
	.tap_sel_ch3(tap_sel_ch3));

// ---- sim/qwr_master.sv ----
// Two-wire bus master model driving the serial clock and data.
`timescale 1ns/1ps
module qwr_master (
	input  wire logic ref_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_rel
);
	// Idle bus: clock high, data released to the pull-up.
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic tick;
		repeat (12) @(negedge ref_clk);
	endtask
	task automatic start;
		sda_rel = 1'b1;
		tick;
		scl = 1'b1;
		tick;
		sda_rel = 1'b0;
		tick;
		scl = 1'b0;
	endtask
	task automatic stop;
		sda_rel = 1'b0;
		tick;
		scl = 1'b1;
		tick;
		sda_rel = 1'b1;
		tick;
	endtask
	task automatic xbyte(input logic [7:0] d, input logic mack,
		output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_rel = (i == 0) ? mack : d[i-1];
			tick;
			scl = 1'b1;
			tick;
			if (i == 0) ack = sda;
			else q[i-1] = sda;
			scl = 1'b0;
		end
	endtask
endmodule

// ---- sim/tb_top.sv ----
// Testbench for the quad wiper register bank.
`timescale 1ns/1ps
module tb_top;
	import qwr_pkg::*;
	localparam logic [7:0] V [4] = '{8'h00, 8'hFF, 8'h5A, 8'h33};
	logic                ref_clk = 1'b0;
	logic                rst = 1'b1;
	logic [2:0]          sel = 3'h5;
	logic                scl, rel, sda_out, sda_oe_n, k, k1, k2;
	logic [7:0]          q, w [4];
	logic [QWR_TAPS-1:0] t [4];
	int                  n_mismatch = 0;
	int                  checks = 0;
	wire                 sda = sda_oe_n & rel;
	always #10 ref_clk = ~ref_clk;
	qwr_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_rel(rel));
	qwr_bank dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .select_pin_0(sel[0]),
		.select_pin_1(sel[1]), .select_pin_2(sel[2]), .wiper_ch0(w[0]),
		.wiper_ch1(w[1]), .wiper_ch2(w[2]), .wiper_ch3(w[3]),
		.tap_sel_ch0(t[0]), .tap_sel_ch1(t[1]), .tap_sel_ch2(t[2]),
		.tap_sel_ch3(t[3]));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t ns: got %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] id, a, d, e);
		m.start;
		m.xbyte(id, 1'b1, q, k);
		m.xbyte(a, 1'b1, q, k1);
		m.xbyte(d, 1'b1, q, k2);
		m.stop;
		chk({5'h00, k, k1, k2}, e);
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d.", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Main sequence: reset, writes, refused ids, wrapping read.
	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		for (int i = 0; i < 4; i++) chk(w[i], QWR_WIPER_RST);
		$display("Test reset done.");
		for (int i = 0; i < 4; i++) begin
			wr({QWR_DEV_TYPE, sel, 1'b0}, 8'(i), V[i], 8'h00);
			chk(w[i], V[i]);
			chk(t[i][V[i]], 8'h01);
			chk(8'($countones(t[i])), 8'h01);
		end
		chk(t[0][0], 8'h01);
		chk(t[1][255], 8'h01);
		$display("Test write done.");
		wr({QWR_DEV_TYPE, ~sel, 1'b0}, 8'h00, 8'h77, 8'h07);
		wr({QWR_DEV_TYPE ^ 4'h1, sel, 1'b0}, 8'h00, 8'h77, 8'h07);
		chk(w[0], V[0]);
		$display("Test refused id done.");
		m.start;
		m.xbyte({QWR_DEV_TYPE, sel, 1'b0}, 1'b1, q, k);
		m.xbyte(8'h02, 1'b1, q, k1);
		m.start;
		m.xbyte({QWR_DEV_TYPE, sel, 1'b1}, 1'b1, q, k2);
		chk({5'h00, k, k1, k2}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			m.xbyte(8'hFF, i == 3, q, k);
			chk(q, V[(i + 2) % 4]);
		end
		m.stop;
		$display("Test read done.");
		// A second reset must bring every written wiper back to mid-scale.
		rst = 1'b1;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		for (int i = 0; i < 4; i++) chk(w[i], QWR_WIPER_RST);
		$display("Test second reset done.");
		complete_run;
	end
	// Watchdog cuts a hung run short.
	initial begin
		#400000;
		n_mismatch++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		complete_run;
	end
endmodule
